// file: rtl/pfu_stage.sv
// Purpose: Power factor under-limit stage with trip and alarm paths
// Assumes: Selected source pulses vld once per 5 ms cycle; block_i is same-clock logic
// Notes:   Operation
// Operation
// - Monitored value is active over apparent power; resistive load reads 1.00.
// - Sole input is three-phase power factor, refreshed every 5 ms.
// - Node mode On, Blocked, Test, Test/Blocked, Off; default On; needs global allow.
// - With forcing enabled, status may be forced to any condition; default Normal.
// - Input taken from source one or two, default source one.
// - Mode, forcing and source are static, untouched by setting group changes.
// - Trip threshold in 0.01 steps, default 0.8; pick-up below it.
// - Separate alarm threshold, default 0.9, active only with alarms enabled.
// - Mode trips only or trips and alarms, default both; alarms off otherwise.
// - Release only above 103 % of threshold; ratio fixed.
// - Expose measured over trip and alarm thresholds in 0.01 steps.
// - Thresholds and mode may change while the stage keeps running.
// - Alarm countdown exposes expected and remaining time, 5 ms steps.
// - Trip countdown exposes expected and signed remaining time, 5 ms steps; here unsigned, held at zero after trip.
// - Condition reports Normal, Start, Trip, Blocked, Alarm Start or Alarm.
// - Block at pick-up gives Blocked only; active start resets on block.
// - Trip and alarm delays are definite time only.
// - Resettable counters and ON and OFF events for all five conditions.
// - Twelve records, one per cycle with ON events: value 20 ms before, at event, 200 ms before.
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
module pfu_stage
    import pfu_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire pfu_wb_req_t          wb_i,
    output pfu_wb_rsp_t               wb_o,
    input  wire pfu_meas_t            meas_one_i,
    input  wire pfu_meas_t            meas_two_i,
    input  wire logic                 block_i,
    output logic      [NFLAG-1:0]     status_o,
    output pfu_cond_t                 cond_o,
    output logic      [NFLAG-1:0]     event_on_o,
    output logic      [NFLAG-1:0]     event_off_o,
    output logic                      io_trip_o,
    output logic                      io_alarm_o
);
    typedef struct packed {
        logic                         ack;
        logic [31:0]                  rdat;
        pfu_mode_t                    mode;
        logic                         mode_en;
        logic                         src;
        logic                         alm_en;
        logic                         force_en;
        pfu_cond_t                    force_cond;
        logic [6:0]                   trip_set;
        logic [6:0]                   alm_set;
        logic [15:0]                  trip_dly;
        logic [15:0]                  alm_dly;
        logic [7:0]                   pf;
        pfu_path_t                    trip_st;
        pfu_path_t                    alm_st;
        logic [15:0]                  trip_rem;
        logic [15:0]                  alm_rem;
        logic [NFLAG-1:0]             flags;
        pfu_cond_t                    cond;
        logic [NFLAG-1:0]             ev_on;
        logic [NFLAG-1:0]             ev_off;
        logic                         io_trip;
        logic                         io_alarm;
        logic [NFLAG-1:0][7:0]        cnt;
        logic [REC_AW-1:0]            rec_ptr;
        logic [REC_AW-1:0]            rec_sel;
        logic [HIST_AW-1:0]           hist_ptr;
        logic                         hist_full;
        logic [PRE_SHORT_N-1:0][7:0]  pre;
        logic [31:0]                  ticks;
    } pfu_state_t;

    pfu_state_t       s_r;
    pfu_state_t       s_nxt;
    pfu_meas_t        meas;
    logic             tick;
    logic [7:0]       pf_in;
    logic             run_off;
    logic             blk_eff;
    logic [7:0]       hist_rd;
    logic [REC_W-1:0] rec_rd;
    logic             rec_we;
    logic [REC_W-1:0] rec_wd;

    function automatic logic held(input logic [7:0] pf, input logic [6:0] set, input logic active);
        logic [15:0] lhs;
        logic [15:0] rhs;
        lhs = 16'(pf) * 16'(PCT_SCALE);
        rhs = 16'(set) * 16'(REL_PCT);
        // Released only once the value climbs past 103 % of the threshold
        held = active ? (lhs <= rhs) : (pf < {1'b0, set});
    endfunction

    function automatic pfu_path_t step(input pfu_path_t st, input logic pick, input logic blk, input logic zero);
        case (st)
            PATH_IDLE:  step = !pick ? PATH_IDLE : (blk ? PATH_BLOCK : PATH_RUN);
            PATH_RUN:   step = (!pick || blk) ? PATH_IDLE : (zero ? PATH_DONE : PATH_RUN);
            PATH_DONE:  step = pick ? PATH_DONE : PATH_IDLE;
            PATH_BLOCK: step = (pick && blk) ? PATH_BLOCK : PATH_IDLE;
            default:    step = PATH_IDLE;
        endcase
    endfunction

    // Definite time only: a fixed count of cycles loaded at start
    function automatic logic [15:0] remain(input pfu_path_t st, input pfu_path_t nx, input logic [15:0] rem,
                                           input logic [15:0] dly);
        if (nx == PATH_RUN && st == PATH_RUN) begin
            remain = rem - 16'h0001;
        end else if (nx == PATH_DONE) begin
            remain = 16'h0000;
        end else if (nx == PATH_RUN) begin
            remain = dly;
        end else begin
            remain = dly;
        end
    endfunction

    function automatic logic [15:0] ratio(input logic [7:0] pf, input logic [6:0] set);
        ratio = (16'(pf) * 16'(PCT_SCALE)) / 16'(set);
    endfunction

    function automatic logic [6:0] clamp_set(input logic [6:0] v);
        clamp_set = (v < SET_MIN) ? SET_MIN : ((v > SET_MAX) ? SET_MAX : v);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    function automatic pfu_cond_t cond_of(input logic [NFLAG-1:0] f);
        if (f[FL_TRIP]) begin
            cond_of = COND_TRIP;
        end else if (f[FL_START]) begin
            cond_of = COND_START;
        end else if (f[FL_ALARM]) begin
            cond_of = COND_ALARM;
        end else if (f[FL_ALM_START]) begin
            cond_of = COND_ALM_START;
        end else if (f[FL_BLOCK]) begin
            cond_of = COND_BLOCKED;
        end else begin
            cond_of = COND_NORMAL;
        end
    endfunction

    function automatic logic [NFLAG-1:0] flags_of(input pfu_cond_t c);
        flags_of = '0;
        case (c)
            COND_START:     flags_of[FL_START] = 1'b1;
            COND_TRIP:      flags_of = NFLAG'((1 << FL_TRIP) | (1 << FL_START));
            COND_BLOCKED:   flags_of[FL_BLOCK] = 1'b1;
            COND_ALM_START: flags_of[FL_ALM_START] = 1'b1;
            COND_ALARM:     flags_of = NFLAG'((1 << FL_ALARM) | (1 << FL_ALM_START));
            default:        flags_of = '0;
        endcase
    endfunction

    assign meas    = s_r.src ? meas_two_i : meas_one_i;
    assign tick    = meas.vld;
    assign pf_in   = (meas.pf > PF_UNITY) ? PF_UNITY : meas.pf;
    assign run_off = s_r.mode_en && s_r.mode == MODE_OFF;
    assign blk_eff = block_i || (s_r.mode_en && (s_r.mode == MODE_BLOCKED || s_r.mode == MODE_TEST_BLOCKED));

    always_comb begin
        logic [31:0]      ctrl_w;
        logic [31:0]      w;
        logic [31:0]      rd;
        logic             req;
        logic             cnt_clr;
        logic             test;
        logic [NFLAG-1:0] fl;
        logic [7:0]       code;
        ctrl_w  = '0;
        w       = '0;
        rd      = '0;
        cnt_clr = 1'b0;
        code    = '0;
        fl      = '0;
        s_nxt   = s_r;
        req     = wb_i.cyc && wb_i.stb && !s_r.ack;
        test    = s_r.mode_en && (s_r.mode == MODE_TEST || s_r.mode == MODE_TEST_BLOCKED);
        ctrl_w[CTRL_MODE_LSB +: 3]  = s_r.mode;
        ctrl_w[CTRL_MODE_EN]        = s_r.mode_en;
        ctrl_w[CTRL_SRC]            = s_r.src;
        ctrl_w[CTRL_ALM_EN]         = s_r.alm_en;
        ctrl_w[CTRL_FORCE_EN]       = s_r.force_en;
        ctrl_w[CTRL_FORCE_LSB +: 3] = s_r.force_cond;
        // Bus writes land at once; forcing and counter clear act in the write cycle, test gating on the next clock, other settings from the next evaluation
        if (req && wb_i.we) begin
            case ({wb_i.adr[7:2], 2'b00})
                OFS_CTRL: begin
                    w                = merge(ctrl_w, wb_i.dat, wb_i.sel);
                    s_nxt.mode       = pfu_mode_t'(w[CTRL_MODE_LSB +: 3]);
                    s_nxt.mode_en    = w[CTRL_MODE_EN];
                    s_nxt.src        = w[CTRL_SRC];
                    s_nxt.alm_en     = w[CTRL_ALM_EN];
                    s_nxt.force_en   = w[CTRL_FORCE_EN];
                    s_nxt.force_cond = pfu_cond_t'(w[CTRL_FORCE_LSB +: 3]);
                    cnt_clr          = w[CTRL_CNT_CLR];
                end
                OFS_TRIP_SET: s_nxt.trip_set = clamp_set(7'(merge({25'h0, s_r.trip_set}, wb_i.dat, wb_i.sel)));
                OFS_ALM_SET:  s_nxt.alm_set = clamp_set(7'(merge({25'h0, s_r.alm_set}, wb_i.dat, wb_i.sel)));
                OFS_TRIP_DLY: s_nxt.trip_dly = 16'(merge({16'h0, s_r.trip_dly}, wb_i.dat, wb_i.sel));
                OFS_ALM_DLY:  s_nxt.alm_dly = 16'(merge({16'h0, s_r.alm_dly}, wb_i.dat, wb_i.sel));
                OFS_REC_SEL:  s_nxt.rec_sel = (wb_i.dat[REC_AW-1:0] < REC_AW'(REC_DEPTH)) ? wb_i.dat[REC_AW-1:0] : '0;
                default: ;
            endcase
        end
        case ({wb_i.adr[7:2], 2'b00})
            OFS_CTRL:     rd = ctrl_w;
            OFS_TRIP_SET: rd = {25'h0, s_r.trip_set};
            OFS_ALM_SET:  rd = {25'h0, s_r.alm_set};
            OFS_TRIP_DLY: rd = {16'h0, s_r.trip_dly};
            OFS_ALM_DLY:  rd = {16'h0, s_r.alm_dly};
            OFS_STATUS:   rd = {11'h0, s_r.flags, s_r.pf, 5'h0, cond_of(s_r.flags)};
            OFS_RATIO:    rd = {ratio(s_r.pf, s_r.alm_set), ratio(s_r.pf, s_r.trip_set)};
            OFS_REMAIN:   rd = {s_r.alm_rem, s_r.trip_rem};
            OFS_CNT:      rd = {s_r.cnt[FL_TRIP], s_r.cnt[FL_START], s_r.cnt[FL_ALARM], s_r.cnt[FL_ALM_START]};
            OFS_CNT_BLK:  rd = {24'h0, s_r.cnt[FL_BLOCK]};
            OFS_REC_SEL:  rd = {28'h0, s_r.rec_sel};
            OFS_REC_DATA: rd = rec_rd[31:0];
            OFS_REC_TIME: rd = {16'h0, rec_rd[REC_W-1:32]};
            OFS_TIME:     rd = s_r.ticks;
            default:      rd = '0;
        endcase
        s_nxt.ack  = req;
        s_nxt.rdat = (req && !wb_i.we) ? rd : s_r.rdat;
        if (tick) begin
            s_nxt.pf      = pf_in;
            s_nxt.ticks   = s_r.ticks + 32'h0000_0001;
            s_nxt.trip_st = run_off ? PATH_IDLE : step(s_r.trip_st,
                            held(pf_in, s_r.trip_set, s_r.trip_st != PATH_IDLE), blk_eff, s_r.trip_rem == '0);
            s_nxt.alm_st  = (run_off || !s_r.alm_en) ? PATH_IDLE : step(s_r.alm_st,
                            held(pf_in, s_r.alm_set, s_r.alm_st != PATH_IDLE), blk_eff, s_r.alm_rem == '0);
            s_nxt.trip_rem = remain(s_r.trip_st, s_nxt.trip_st, s_r.trip_rem, s_r.trip_dly);
            s_nxt.alm_rem  = remain(s_r.alm_st, s_nxt.alm_st, s_r.alm_rem, s_r.alm_dly);
            s_nxt.pre      = {s_r.pre[PRE_SHORT_N-2:0], pf_in};
            s_nxt.hist_ptr = (s_r.hist_ptr == HIST_AW'(PRE_LONG_N - 1)) ? '0 : s_r.hist_ptr + 1'b1;
            s_nxt.hist_full = s_r.hist_full || s_r.hist_ptr == HIST_AW'(PRE_LONG_N - 1);
        end
        fl[FL_START]     = s_nxt.trip_st == PATH_RUN || s_nxt.trip_st == PATH_DONE;
        fl[FL_TRIP]      = s_nxt.trip_st == PATH_DONE;
        fl[FL_ALM_START] = s_nxt.alm_st == PATH_RUN || s_nxt.alm_st == PATH_DONE;
        fl[FL_ALARM]     = s_nxt.alm_st == PATH_DONE;
        fl[FL_BLOCK]     = s_nxt.trip_st == PATH_BLOCK || s_nxt.alm_st == PATH_BLOCK;
        s_nxt.flags    = s_nxt.force_en ? flags_of(s_nxt.force_cond) : fl;
        s_nxt.cond     = cond_of(s_nxt.flags);
        // Test modes show the condition but keep the hard outputs quiet
        s_nxt.io_trip  = s_nxt.flags[FL_TRIP] && !test;
        s_nxt.io_alarm = s_nxt.flags[FL_ALARM] && !test;
        s_nxt.ev_on    = s_nxt.flags & ~s_r.flags;
        s_nxt.ev_off   = s_r.flags & ~s_nxt.flags;
        // A counted event in the clearing cycle survives the clear
        for (int i = 0; i < NFLAG; i++) begin
            if (cnt_clr) begin
                s_nxt.cnt[i] = {7'h00, s_nxt.ev_on[i]};
            end else begin
                s_nxt.cnt[i] = s_r.cnt[i] + {7'h00, s_nxt.ev_on[i]};
            end
            if (s_nxt.ev_on[i]) begin
                code = 8'(i);
            end
        end
        rec_we = |s_nxt.ev_on;
        rec_wd = {s_r.ticks[15:0], code, s_r.pre[PRE_SHORT_N-1], pf_in, s_r.hist_full ? hist_rd : 8'h00};
        if (rec_we) begin
            s_nxt.rec_ptr = (s_r.rec_ptr == REC_AW'(REC_DEPTH - 1)) ? '0 : s_r.rec_ptr + 1'b1;
        end
        if (rst_i) begin
            s_nxt          = '0;
            s_nxt.trip_set = TRIP_SET_RST;
            s_nxt.alm_set  = ALM_SET_RST;
            s_nxt.trip_dly = TRIP_DLY_RST;
            s_nxt.alm_dly  = ALM_DLY_RST;
            s_nxt.trip_rem = TRIP_DLY_RST;
            s_nxt.alm_rem  = ALM_DLY_RST;
            s_nxt.alm_en   = 1'b1;
            rec_we         = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    // Slot at the write pointer holds the value forty cycles old
    pfu_mem #(.WIDTH(8), .DEPTH(PRE_LONG_N), .AW(HIST_AW)) u_hist (
        .clk_i (clk_i),
        .we_i  (tick && !rst_i),
        .wa_i  (s_r.hist_ptr),
        .wd_i  (pf_in),
        .ra_i  (s_r.hist_ptr),
        .rd_o  (hist_rd)
    );

    pfu_mem #(.WIDTH(REC_W), .DEPTH(REC_DEPTH), .AW(REC_AW)) u_rec (
        .clk_i (clk_i),
        .we_i  (rec_we),
        .wa_i  (s_r.rec_ptr),
        .wd_i  (rec_wd),
        .ra_i  (s_r.rec_sel),
        .rd_o  (rec_rd)
    );

    assign wb_o        = {s_r.ack, s_r.rdat};
    assign status_o    = s_r.flags;
    assign cond_o      = s_r.cond;
    assign event_on_o  = s_r.ev_on;
    assign event_off_o = s_r.ev_off;
    assign io_trip_o   = s_r.io_trip;
    assign io_alarm_o  = s_r.io_alarm;

    AST_PF_CLAMP: assert property (@(posedge clk_i) disable iff (rst_i) s_r.pf <= PF_UNITY)
        else $error("stored power factor above unity");
    AST_PICKUP: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && !run_off && !blk_eff && s_r.trip_st == PATH_IDLE && pf_in < {1'b0, s_r.trip_set})
        |=> s_r.trip_st == PATH_RUN && s_r.trip_rem == $past(s_r.trip_dly))
        else $error("pick-up below threshold did not start countdown");
    AST_BLOCK_AT_PICKUP: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && !run_off && blk_eff && s_r.trip_st == PATH_IDLE && pf_in < {1'b0, s_r.trip_set})
        |=> s_r.trip_st == PATH_BLOCK && s_r.flags[FL_START] == 1'b0)
        else $error("blocked pick-up did not report blocked");
    AST_START_DROPS: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && blk_eff && s_r.trip_st == PATH_RUN) |=> s_r.trip_st == PATH_IDLE)
        else $error("start survived a block");
    AST_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && s_r.trip_st == PATH_RUN && !held(pf_in, s_r.trip_set, 1'b1)) |=> s_r.trip_st == PATH_IDLE)
        else $error("no release above 103 percent");
    AST_COUNTDOWN: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && !run_off && !blk_eff && s_r.trip_st == PATH_RUN && s_r.trip_rem != '0
         && held(pf_in, s_r.trip_set, 1'b1))
        |=> s_r.trip_st == PATH_RUN && s_r.trip_rem == $past(s_r.trip_rem) - 16'h0001)
        else $error("remaining time did not drop one step");
    AST_TRIP_ON_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && !run_off && !blk_eff && s_r.trip_st == PATH_RUN && s_r.trip_rem == '0
         && held(pf_in, s_r.trip_set, 1'b1)) |=> s_r.trip_st == PATH_DONE)
        else $error("countdown at zero did not trip");
    AST_TRIP_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_r.trip_st == PATH_DONE && !s_r.force_en) |-> cond_o == COND_TRIP && s_r.flags[FL_START])
        else $error("trip state not reported");
    AST_NO_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
        !tick |=> $stable(s_r.trip_st) && $stable(s_r.trip_rem) && $stable(s_r.alm_st))
        else $error("evaluation outside a processing cycle");
    AST_TRIPS_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && !s_r.alm_en) |=> s_r.alm_st == PATH_IDLE && !s_r.flags[FL_ALM_START] ##1 !io_alarm_o)
        else $error("alarm active in trips-only mode");
endmodule

// file: rtl/pfu_pkg.sv
// Purpose: Shared constants and types of the power factor under-limit stage
// Assumes: Power factor arrives in hundredths, 100 meaning unity
// Notes:   Byte offsets are word aligned on a 32-bit classic Wishbone slave
package pfu_pkg;
    // Processing time base and record depths
    localparam int TICK_MS      = 5;
    localparam int PRE_SHORT_MS = 20;
    localparam int PRE_LONG_MS  = 200;
    localparam int PRE_SHORT_N  = PRE_SHORT_MS / TICK_MS;
    localparam int PRE_LONG_N   = PRE_LONG_MS / TICK_MS;
    localparam int REC_DEPTH    = 12;
    localparam int HIST_AW      = $clog2(PRE_LONG_N);
    localparam int REC_AW       = $clog2(REC_DEPTH);
    localparam int REC_W        = 48;

    // Power factor scaling and fixed release ratio
    localparam logic [7:0] PF_UNITY  = 8'h64;
    localparam logic [7:0] PCT_SCALE = 8'h64;
    localparam logic [7:0] REL_PCT   = 8'h67;
    localparam logic [6:0] SET_MIN   = 7'h05;
    localparam logic [6:0] SET_MAX   = 7'h63;

    // Reset values
    localparam logic [6:0]  TRIP_SET_RST = 7'h50;
    localparam logic [6:0]  ALM_SET_RST  = 7'h5A;
    localparam logic [15:0] TRIP_DLY_RST = 16'h0064;
    localparam logic [15:0] ALM_DLY_RST  = 16'h00C8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_TRIP_SET = 8'h04;
    localparam logic [7:0] OFS_ALM_SET  = 8'h08;
    localparam logic [7:0] OFS_TRIP_DLY = 8'h0C;
    localparam logic [7:0] OFS_ALM_DLY  = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_RATIO    = 8'h18;
    localparam logic [7:0] OFS_REMAIN   = 8'h1C;
    localparam logic [7:0] OFS_CNT      = 8'h20;
    localparam logic [7:0] OFS_CNT_BLK  = 8'h24;
    localparam logic [7:0] OFS_REC_SEL  = 8'h28;
    localparam logic [7:0] OFS_REC_DATA = 8'h2C;
    localparam logic [7:0] OFS_REC_TIME = 8'h30;
    localparam logic [7:0] OFS_TIME     = 8'h34;

    // Control and status field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_MODE_EN   = 3;
    localparam int CTRL_SRC       = 4;
    localparam int CTRL_ALM_EN    = 5;
    localparam int CTRL_FORCE_EN  = 6;
    localparam int CTRL_FORCE_LSB = 8;
    localparam int CTRL_CNT_CLR   = 12;
    localparam int STAT_COND_LSB  = 0;
    localparam int STAT_PF_LSB    = 8;
    localparam int STAT_FLAG_LSB  = 16;

    // Flag positions, also event and counter order
    localparam int FL_ALM_START = 0;
    localparam int FL_ALARM     = 1;
    localparam int FL_START     = 2;
    localparam int FL_TRIP      = 3;
    localparam int FL_BLOCK     = 4;
    localparam int NFLAG        = 5;

    typedef enum logic [2:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF} pfu_mode_t;
    typedef enum logic [2:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED, COND_ALM_START, COND_ALARM} pfu_cond_t;
    typedef enum logic [1:0] {PATH_IDLE, PATH_RUN, PATH_DONE, PATH_BLOCK} pfu_path_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } pfu_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } pfu_wb_rsp_t;

    typedef struct packed {
        logic       vld;
        logic [7:0] pf;
    } pfu_meas_t;
endpackage

// file: rtl/pfu_mem.sv
// Purpose: Small single-clock memory with registered read data
// Assumes: One write and one read port on the same clock
// Notes:   Contents are not reset; callers track which words are valid
`timescale 1ns/1ps
module pfu_mem
    import pfu_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    wa_i,
    input  wire logic [WIDTH-1:0] wd_i,
    input  wire logic [AW-1:0]    ra_i,
    output logic      [WIDTH-1:0] rd_o
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[wa_i] <= wd_i;
        end
        rd_o <= mem_r[ra_i];
    end
endmodule

// file: testbench/pfu_meas_model.sv
// Purpose: Power measurement sources feeding the stage
// Assumes: One tick every PERIOD clocks
// Notes:   Source two sits at unity so a wrong pick never picks up
`timescale 1ns/1ps
module pfu_meas_model
    import pfu_pkg::*;
#(
    parameter int PERIOD = 8
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] pf_i,
    output pfu_meas_t       meas_one_o,
    output pfu_meas_t       meas_two_o
);
    int cnt_r;
    always_ff @(posedge clk_i) begin
        cnt_r      <= (rst_i || cnt_r == PERIOD-1) ? 0 : cnt_r + 1;
        // Value between ticks is not valid, so show its inverse
        meas_one_o <= '{!rst_i && cnt_r == PERIOD-1, (cnt_r == PERIOD-1) ? pf_i : ~pf_i};
        meas_two_o <= '{!rst_i && cnt_r == 2, PF_UNITY};
    end
endmodule

// file: testbench/pfu_stage_bench.sv
// Purpose: Self-checking bench of the power factor stage
// Assumes: Tick every 8 clocks, short delays
// Notes:   Expected ratios come from bench arithmetic
`timescale 1ns/1ps
module pfu_stage_bench
    import pfu_pkg::*;
;
    logic             clk_i = 0, rst_i = 1, block_i = 0, trip, alarm;
    logic [7:0]       pf = 8'h64;
    pfu_wb_req_t      wb = '0;
    pfu_wb_rsp_t      wb_o;
    pfu_meas_t        m1, m2;
    logic [NFLAG-1:0] st;
    logic [NFLAG-1:0] ev_on, ev_off;
    int               n_ton = 0, n_toff = 0;
    pfu_cond_t        cond;
    logic [31:0]      q;
    int               n_fail = 0, check_count = 0, p;
    initial forever #2.5 clk_i = ~clk_i;
    pfu_meas_model pfu_meas_model_i (.clk_i(clk_i), .rst_i(rst_i), .pf_i(pf), .meas_one_o(m1), .meas_two_o(m2));
    pfu_stage pfu_stage_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_o(wb_o), .meas_one_i(m1), .meas_two_i(m2),
        .block_i(block_i), .status_o(st), .cond_o(cond), .event_on_o(ev_on), .event_off_o(ev_off),
        .io_trip_o(trip), .io_alarm_o(alarm));
    // Pulses stand one cycle, so every edge must look at them
    always @(posedge clk_i) begin
        n_ton  <= n_ton + int'(ev_on[FL_TRIP]);
        n_toff <= n_toff + int'(ev_off[FL_TRIP]);
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb <= '{1'b1, 1'b1, we, a, 4'hF, d};
        @(posedge clk_i);
        while (wb_o.ack !== 1'b1) @(posedge clk_i);
        q = wb_o.dat;
        wb.cyc <= 1'b0;
        wb.stb <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n * 8) @(posedge clk_i);
    endtask
    function automatic logic [15:0] ratio(input int v, input int thr);
        return 16'(v * 100 / thr);
    endfunction
    initial begin
        #100000;
        n_fail++;
        conclude();
    end
    initial begin
        void'($urandom(32'h0583_2743));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, OFS_TRIP_SET, 0);
        chk(q, 32'h0000_0050);
        bus(0, OFS_ALM_SET, 0);
        chk(q, 32'h0000_005A);
        bus(0, 8'hFC, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        bus(1, OFS_TRIP_DLY, 32'h0000_0004);
        bus(1, OFS_CTRL, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            p = (k == 0) ? 79 : 5 + $urandom % 75;
            pf <= 8'(p);
            ticks(2);
            chk(32'(cond), 32'(COND_START));
            ticks(5);
            chk({27'h0, st}, 32'h0000_000C);
            chk({31'h0, trip}, 32'h0000_0001);
            bus(0, OFS_RATIO, 0);
            chk(q, {ratio(p, 90), ratio(p, 80)});
            // Just under 103 % must hold the trip
            pf <= 8'h52;
            ticks(2);
            chk(32'(cond), 32'(COND_TRIP));
            pf <= 8'h53;
            ticks(2);
            chk(32'(cond), 32'(COND_NORMAL));
            bus(0, OFS_REMAIN, 0);
            chk({16'h0, q[15:0]}, 32'h0000_0004);
        end
        chk({n_ton[15:0], n_toff[15:0]}, 32'h0003_0003);
        bus(0, OFS_CNT, 0);
        chk(q, 32'h0303_0000);
        bus(0, OFS_REC_DATA, 0);
        chk({16'h0, q[31:24], q[15:8]}, 32'h0000_024F);
        // Source two sits at unity, so a low value on source one must be ignored
        bus(1, OFS_CTRL, 32'h0000_1010);
        pf <= 8'h10;
        ticks(3);
        chk(32'(cond), 32'(COND_NORMAL));
        bus(0, OFS_CNT, 0);
        chk(q, 32'h0000_0000);
        pf <= 8'h55;
        ticks(2);
        bus(1, OFS_ALM_DLY, 32'h0000_0002);
        bus(1, OFS_CTRL, 32'h0000_0020);
        pf <= 8'h55;
        ticks(6);
        chk({28'h0, st[3:0], alarm}, 32'h0000_0007);
        pf <= 8'h64;
        block_i <= 1'b1;
        ticks(2);
        pf <= 8'h32;
        ticks(2);
        chk({28'h0, cond, trip}, {28'h0, COND_BLOCKED, 1'b0});
        block_i <= 1'b0;
        bus(1, OFS_CTRL, 32'h0000_002A);
        ticks(9);
        chk({25'h0, st, trip, alarm}, 32'h0000_003C);
        bus(1, OFS_CTRL, 32'h0000_000C);
        ticks(2);
        chk({27'h0, st}, 32'h0000_0000);
        pf <= 8'h64;
        bus(1, OFS_CTRL, 32'h0000_0240);
        ticks(1);
        chk(32'(cond), 32'(COND_TRIP));
        conclude();
    end
endmodule
